/* hdl/sbd_bank_decode.sv */
`timescale 1ns/1ns
// Behaviour
// R01 - Three capacities 36, 20, 12 kB; each has two equal blocks plus 4 kB
// R02 - Lowest block always enabled; nothing can switch it off
// R03 - Middle and top blocks have independent enables for power saving
// R04 - All blocks contiguous from 0x0200_0000 without gaps
// R05 - Largest: base to 3FFF, mid 4000-7FFF, top 8000-8FFF
// R06 - Two 512 kB peripheral regions, each decoding up to 32 slots
// R07 - Each peripheral gets fixed 16 kB slot from upper address bits
// R08 - Middle and top enables come out of reset set
module sbd_bank_decode (
	input wire logic clock_i, // System clock
	input wire logic resetn_i, // Sync reset, active low
	input wire logic [1:0] cfg_i, // Capacity configuration
	input wire logic en_mid_wr_i, // Load middle block enable
	input wire logic en_mid_i, // New middle block enable
	input wire logic en_top_wr_i, // Load top block enable
	input wire logic en_top_i, // New top block enable
	input wire logic req_i, // Address valid
	input wire logic [31:0] addr_i, // Bus address
	output logic sel_base_o, // Base block select
	output logic sel_mid_o, // Middle block select
	output logic sel_top_o, // Top block select
	output logic ram_miss_o, // RAM range hit on disabled or no block
	output logic en_mid_o, // Middle block enable state
	output logic en_top_o, // Top block enable state
	output logic per_hit_o, // Peripheral region hit
	output logic per_region_o, // Peripheral region index
	output logic [31:0] per_sel_o // One-hot peripheral slot select
);

	// ==========================================================
	// Local sizes

	// Slot index width and number of slots in one region
	localparam int SW = sbd_pkg::PER_SLOT_W;
	localparam int NSLOT = 1 << SW;

	// Miss window always spans the largest capacity
	localparam logic [31:0] RAM_SPAN = sbd_pkg::LOW_BLK_36K
		+ sbd_pkg::LOW_BLK_36K + sbd_pkg::TOP_BLK;

	// Zero offset, start of the first window
	localparam logic [31:0] OFF_ZERO = 32'h0000_0000;

	// ==========================================================
	// Decode helpers

	// Lower block size for a capacity code; spare code acts as smallest
	function automatic logic [31:0] low_size(input logic [1:0] c);
		case (c)
			sbd_pkg::SBD_CFG_36K: low_size = sbd_pkg::LOW_BLK_36K; // [R01]
			sbd_pkg::SBD_CFG_20K: low_size = sbd_pkg::LOW_BLK_20K; // [R01]
			default: low_size = sbd_pkg::LOW_BLK_12K; // [R01]
		endcase
	endfunction

	// Address falls in the peripheral region that starts at base
	function automatic logic region_match(
		input logic [31:0] a,
		input logic [31:0] b
	);
		region_match = a[31:sbd_pkg::PER_REGION_LSB]
			== b[31:sbd_pkg::PER_REGION_LSB]; // [R06]
	endfunction

	// Offset lies in the half-open window from lo up to hi
	function automatic logic in_window(
		input logic [31:0] o,
		input logic [31:0] lo,
		input logic [31:0] hi
	);
		in_window = o >= lo && o < hi;
	endfunction

	// ==========================================================
	// RAM block decode
	logic [31:0] blk;
	logic [31:0] off;
	logic [31:0] end_base;
	logic [31:0] end_mid;
	logic [31:0] end_top;
	logic in_ram;
	logic in_base;
	logic in_mid;
	logic in_top;
	logic in_span;

	// Block boundaries follow one another with no gap
	assign blk = low_size(cfg_i); // [R01]
	assign off = addr_i - sbd_pkg::RAM_BASE; // [R04]
	assign end_base = blk; // [R05]
	assign end_mid = blk + blk; // [R04] [R05]
	assign end_top = end_mid + sbd_pkg::TOP_BLK; // [R01] [R04]

	// Offset wraps below the base, so every window is gated
	assign in_ram = addr_i >= sbd_pkg::RAM_BASE; // [R04]
	assign in_base = in_ram && in_window(off, OFF_ZERO, end_base);
	assign in_mid = in_ram && in_window(off, end_base, end_mid);
	assign in_top = in_ram && in_window(off, end_mid, end_top);
	assign in_span = in_ram && in_window(off, OFF_ZERO, RAM_SPAN);

	// ==========================================================
	// Block enables
	logic en_mid_q;
	logic en_mid_d;
	logic en_top_q;
	logic en_top_d;

	// A write loads the new value, otherwise the enable holds
	assign en_mid_d = en_mid_wr_i ? en_mid_i : en_mid_q; // [R03]
	assign en_top_d = en_top_wr_i ? en_top_i : en_top_q; // [R03]

	// Enable flops; both come out of reset set
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			en_mid_q <= sbd_pkg::EN_MID_RST; // [R08]
			en_top_q <= sbd_pkg::EN_TOP_RST; // [R08]
		end else begin
			en_mid_q <= en_mid_d;
			en_top_q <= en_top_d;
		end
	end

	// Enable state for the rest of the system
	assign en_mid_o = en_mid_q;
	assign en_top_o = en_top_q;

	// ==========================================================
	// Block selects
	logic sel_base_d;
	logic sel_mid_d;
	logic sel_top_d;
	logic ram_miss_d;
	logic served;
	logic sel_base_q;
	logic sel_mid_q;
	logic sel_top_q;
	logic ram_miss_q;

	// Base block has no enable term at all
	assign sel_base_d = req_i && in_base; // [R02]

	// Upper blocks use the enable held before this edge
	assign sel_mid_d = req_i && in_mid && en_mid_q; // [R03]
	assign sel_top_d = req_i && in_top && en_top_q; // [R03]

	// Any enabled block answering this request
	assign served = sel_base_d || sel_mid_d || sel_top_d;

	// Miss covers the largest span, whatever the capacity
	assign ram_miss_d = req_i && in_span && !served; // [R03]

	// Select flops, one cycle after the request
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			sel_base_q <= 1'b0;
			sel_mid_q <= 1'b0;
			sel_top_q <= 1'b0;
			ram_miss_q <= 1'b0;
		end else begin
			sel_base_q <= sel_base_d;
			sel_mid_q <= sel_mid_d;
			sel_top_q <= sel_top_d;
			ram_miss_q <= ram_miss_d;
		end
	end

	// Registered selects to the RAM blocks
	assign sel_base_o = sel_base_q;
	assign sel_mid_o = sel_mid_q;
	assign sel_top_o = sel_top_q;
	assign ram_miss_o = ram_miss_q;

	// ==========================================================
	// Peripheral decode
	logic hit0;
	logic hit1;
	logic per_hit_d;
	logic per_region_d;
	logic [SW-1:0] slot;
	logic [NSLOT-1:0] per_sel_d;
	logic per_hit_q;
	logic per_region_q;
	logic [NSLOT-1:0] per_sel_q;

	// Region hits for the two peripheral areas
	assign hit0 = region_match(addr_i, sbd_pkg::PER_BASE0); // [R06]
	assign hit1 = region_match(addr_i, sbd_pkg::PER_BASE1); // [R06]

	// Fixed slot index straight from the upper address bits
	assign slot =
		addr_i[sbd_pkg::PER_REGION_LSB-1:sbd_pkg::PER_SLOT_LSB]; // [R07]

	// Hit and region only for a valid request
	assign per_hit_d = req_i && (hit0 || hit1); // [R06]
	assign per_region_d = req_i && hit1; // [R06]

	// One comparator per slot gives the one-hot select
	genvar gi;
	generate
		for (gi = 0; gi < NSLOT; gi++) begin : g_slot
			assign per_sel_d[gi] = per_hit_d && slot == SW'(gi); // [R07]
		end
	endgenerate

	// Peripheral flops, one cycle after the request
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			per_hit_q <= 1'b0;
			per_region_q <= 1'b0;
			per_sel_q <= '0;
		end else begin
			per_hit_q <= per_hit_d;
			per_region_q <= per_region_d;
			per_sel_q <= per_sel_d;
		end
	end

	// Registered peripheral outputs
	assign per_hit_o = per_hit_q;
	assign per_region_o = per_region_q;
	assign per_sel_o = per_sel_q;

endmodule

/* inc/sbd_pkg.sv */
package sbd_pkg;

	// ==========================================================
	// Address map
	localparam logic [31:0] RAM_BASE = 32'h0200_0000;
	localparam int ADDR_W = 32;

	// ==========================================================
	// Capacity configurations
	typedef enum logic [1:0] {
		SBD_CFG_36K = 2'b00,
		SBD_CFG_20K = 2'b01,
		SBD_CFG_12K = 2'b10
	} sbd_cfg_e;

	// Lower block sizes in bytes, top block fixed
	localparam logic [31:0] LOW_BLK_36K = 32'h0000_4000;
	localparam logic [31:0] LOW_BLK_20K = 32'h0000_2000;
	localparam logic [31:0] LOW_BLK_12K = 32'h0000_1000;
	localparam logic [31:0] TOP_BLK = 32'h0000_1000;

	// ==========================================================
	// Peripheral bus areas
	localparam logic [31:0] PER_BASE0 = 32'h4000_0000;
	localparam logic [31:0] PER_BASE1 = 32'h4008_0000;
	localparam int PER_REGION_LSB = 19;
	localparam int PER_SLOT_LSB = 14;
	localparam int PER_SLOT_W = 5;

	// ==========================================================
	// Reset values of block enables
	localparam logic EN_MID_RST = 1'b1;
	localparam logic EN_TOP_RST = 1'b1;

endpackage

/* testbench/sbd_bank_decode_props.sv */
`timescale 1ns/1ns
module sbd_bank_decode_props (
	input wire logic clock_i, resetn_i, en_mid_wr_i, en_mid_i, en_top_wr_i,
	input wire logic en_top_i, req_i, sel_base_o, sel_mid_o, sel_top_o,
	input wire logic ram_miss_o, en_mid_o, en_top_o, // Selects, enables
	input wire logic per_hit_o, per_region_o, // Peripheral hit, region
	input wire logic [1:0] cfg_i, // Capacity
	input wire logic [31:0] addr_i, per_sel_o // Address, slots
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!resetn_i);
	// Lower block size and offset into RAM
	wire [15:0] l = cfg_i == 2'h0 ? 16'h4000 :
		cfg_i == 2'h1 ? 16'h2000 : 16'h1000;
	wire [31:0] o = addr_i - 32'h0200_0000;
	base_sel_a: assert property (
		req_i && o < l |=> sel_base_o)
		else $error("base block not selected");
	base_miss_a: assert property (
		req_i && o < l |=> !ram_miss_o)
		else $error("miss on base block");
	mid_sel_a: assert property (
		req_i && o - l < l |=> sel_mid_o == $past(en_mid_o))
		else $error("mid select wrong");
	top_sel_a: assert property (
		req_i && o - 2 * l < 16'h1000 |=> sel_top_o == $past(en_top_o))
		else $error("top select wrong");
	ram_miss_a: assert property (
		req_i && o < 32'h0000_9000 && o >= 2 * l + 16'h1000 |=> ram_miss_o)
		else $error("miss not flagged");
	mid_en_a: assert property (
		en_mid_wr_i |=> en_mid_o == $past(en_mid_i))
		else $error("mid enable not loaded");
	top_en_a: assert property (
		en_top_wr_i |=> en_top_o == $past(en_top_i))
		else $error("top enable not loaded");
	per_slot_a: assert property (
		req_i && addr_i[31:20] == 12'h400 |=>
		per_sel_o == 32'h1 << $past(addr_i[18:14]))
		else $error("slot wrong");
	per_region_a: assert property (
		req_i && addr_i[31:20] == 12'h400 |=>
		per_hit_o && per_region_o == $past(addr_i[19]))
		else $error("region wrong");
	rst_en_a: assert property (
		$rose(resetn_i) |-> en_mid_o && en_top_o)
		else $error("enables clear after reset");
endmodule
bind sbd_bank_decode sbd_bank_decode_props u_sbd_bank_decode_props (
	.clock_i(clock_i),
	.resetn_i(resetn_i),
	.en_mid_wr_i(en_mid_wr_i),
	.en_mid_i(en_mid_i),
	.en_top_wr_i(en_top_wr_i),
	.en_top_i(en_top_i),
	.req_i(req_i),
	.sel_base_o(sel_base_o),
	.sel_mid_o(sel_mid_o),
	.sel_top_o(sel_top_o),
	.ram_miss_o(ram_miss_o),
	.en_mid_o(en_mid_o),
	.en_top_o(en_top_o),
	.per_hit_o(per_hit_o),
	.per_region_o(per_region_o),
	.cfg_i(cfg_i),
	.addr_i(addr_i),
	.per_sel_o(per_sel_o)
);

/* testbench/sbd_bus_master.sv */
`timescale 1ns/1ns
module sbd_bus_master (
	input wire logic clock_i, // Clock
	output logic req_o = 1'b0, // Address valid
	output logic [31:0] addr_o = 32'h0000_0000 // Address
);
	// Drive just after the edge; an idle bus shows the inverted address
	task automatic issue(input logic r, input logic [31:0] a);
		@(posedge clock_i);
		#1 req_o = r;
		addr_o = r ? a : ~addr_o;
	endtask
endmodule

/* testbench/test_sbd_bank_decode.sv */
`timescale 1ns/1ns
module test_sbd_bank_decode;
	logic clock_i = 1'b0, resetn_i = 1'b0, req_q = 1'b0, em = 1'b1, et = 1'b1;
	logic en_mid_wr_i = 1'b0, en_top_wr_i = 1'b0, en_mid_i = 1'b0, w, h;
	logic en_top_i = 1'b0, req_i, sel_base_o, sel_mid_o, sel_top_o, ram_miss_o;
	logic en_mid_o, en_top_o, per_hit_o, per_region_o;
	logic [1:0] cfg_i = 2'h0;
	logic [2:0] s;
	logic [31:0] addr_i, per_sel_o, a, x, o, l;
	logic [39:0] q[$], e;
	int failures = 0, check_count = 0;
	int n = 0;
	wire [39:0] seen = {en_mid_o, en_top_o, sel_base_o, sel_mid_o, sel_top_o,
		ram_miss_o, per_hit_o, per_region_o & per_hit_o, per_sel_o};
	initial forever #50 clock_i = ~clock_i;
	sbd_bus_master u_sbd_bus_master (.clock_i, .req_o(req_i), .addr_o(addr_i));
	sbd_bank_decode u_sbd_bank_decode (
		.clock_i(clock_i),
		.resetn_i(resetn_i),
		.cfg_i(cfg_i),
		.en_mid_wr_i(en_mid_wr_i),
		.en_mid_i(en_mid_i),
		.en_top_wr_i(en_top_wr_i),
		.en_top_i(en_top_i),
		.req_i(req_i),
		.addr_i(addr_i),
		.sel_base_o(sel_base_o),
		.sel_mid_o(sel_mid_o),
		.sel_top_o(sel_top_o),
		.ram_miss_o(ram_miss_o),
		.en_mid_o(en_mid_o),
		.en_top_o(en_top_o),
		.per_hit_o(per_hit_o),
		.per_region_o(per_region_o),
		.per_sel_o(per_sel_o)
	);
	always @(posedge clock_i) req_q <= req_i;
	// Each answer against the oldest prediction
	always @(negedge clock_i) if (req_q) begin
		check_count++;
		if (q.size() == 0) begin
			failures++;
			$display("[FAIL] decode note expected queued seen %h", seen);
		end else begin
			e = q.pop_front();
			if (e !== seen) begin
				failures++;
				$display("[FAIL] decode outputs expected %h seen %h", e, seen);
			end
		end
	end
	// Random requests near every block edge, plus enable writes
	initial begin
		a = $urandom(33937);
		repeat (20) @(posedge clock_i);
		#1 resetn_i = 1'b1;
		repeat (600) begin
			n++;
			// Mid-run reset: enables must come back set
			if (n == 300) begin
				u_sbd_bus_master.issue(1'b0, x);
				{en_mid_wr_i, en_top_wr_i} = 2'b00;
				resetn_i = 1'b0;
				repeat (3) @(posedge clock_i);
				#1 resetn_i = 1'b1;
				{em, et} = 2'b11;
			end
			a = $urandom;
			w = a[2:0] == 3'h0;
			x = {16'h0200, a[31:28] % 4'ha, 12'h000} - a[5];
			if (a[4]) x = a[3] ? $urandom : {12'h400, a[31:12]};
			u_sbd_bus_master.issue(!w, x);
			{cfg_i, en_mid_i, en_top_i} = a[9:6];
			{en_mid_wr_i, en_top_wr_i} = {w & a[10], w & a[11]};
			em = en_mid_wr_i ? en_mid_i : em;
			et = en_top_wr_i ? en_top_i : et;
			l = 32'h0000_4000 >> (cfg_i == 2'h3 ? 2'h2 : cfg_i);
			o = x - 32'h0200_0000;
			s = {o < l, em && o - l < l, et && o - 2 * l < 32'h0000_1000};
			h = x[31:20] == 12'h400;
			if (!w) q.push_back({em, et, s, !s && o < 32'h0000_9000,
				h, h & x[19], h ? 32'h1 << x[18:14] : 32'h0});
		end
		u_sbd_bus_master.issue(1'b0, x);
		repeat (2) @(posedge clock_i);
		give_verdict();
	end
	task automatic give_verdict;
		if (q.size() != 0) begin
			failures++;
			$display("[FAIL] pending notes expected 0 seen %0d", q.size());
		end
		$display("compared %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
endmodule
